// *** blit_pkg.sv ***
// shared constants and types of the graphics block transfer unit
package blit_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 24;

  // ==========================================================================
  // block transfer instruction word layout
  localparam int unsigned BB_DEC_BIT  = 17;
  localparam int unsigned BB_AND_BIT  = 16;
  localparam int unsigned BB_INV_BIT  = 15;
  localparam int unsigned BB_ZERO_BIT = 14;
  localparam int unsigned BB_OP_LSB   = 10;
  localparam int unsigned BB_SIZE_LSB = 8;
  localparam int unsigned BB_HI_LSB   = 18;
  localparam logic [5:0]  BB_HI_VAL   = 6'h00;
  localparam logic [7:0]  BB_LOW_VAL  = 8'h0E;

  // ==========================================================================
  // operation and size field codes
  localparam logic [3:0] OPF_AND   = 4'hA;
  localparam logic [3:0] OPF_OR    = 4'h6;
  localparam logic [3:0] OPF_XOR   = 4'hE;
  localparam logic [3:0] OPF_FOR   = 4'hC;
  localparam logic [3:0] OPF_COPY  = 4'h4;
  localparam logic [1:0] SIZE_AND  = 2'h3;
  localparam logic [1:0] SIZE_REST = 2'h1;

  // ==========================================================================
  // pointer and data constants
  localparam logic [31:0]       WORD_STEP  = 32'h0000_0002;
  localparam logic [31:0]       ONE        = 32'h0000_0001;
  localparam int unsigned       BYTE_SHIFT = 3;
  localparam logic [WORD_W-1:0] MASK_ALL   = 16'hFFFF;

  // ==========================================================================
  // types
  typedef logic [WORD_W-1:0] word_t;

  typedef enum logic [1:0] {LOP_AND, LOP_OR, LOP_XOR, LOP_COPY} logic_op_t;

  typedef enum logic [2:0] {CMD_BLOCK, CMD_WORD_OR, CMD_EXTERNAL, CMD_PATTERN, CMD_BIT_RUN} cmd_kind_t;

  typedef struct packed {
    logic [31:0] gpr7;
    logic [31:0] gpr6;
    logic [31:0] gpr5;
    logic [31:0] gpr4;
    logic [31:0] gpr3;
    logic [31:0] gpr2;
    logic [31:0] gpr1;
    logic [31:0] gpr0;
  } gpr_file_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic_op_t   op;
    logic        inv;
    logic [3:0]  shift;
  } blit_cfg_t;

  typedef struct packed {
    logic      ok;
    logic_op_t op;
    logic      inv;
    logic      dec;
  } bb_dec_t;

endpackage : blit_pkg

// *** read_buffer.sv ***
// two-entry buffer for memory read data
module read_buffer
  import blit_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              in_valid_i,
  input  wire logic [DATA_W-1:0] in_data_i,
  output logic                   in_ready_o,
  output logic                   out_valid_o,
  output logic [DATA_W-1:0]      out_data_o,
  input  wire logic              out_ready_i
);

  typedef struct packed {
    logic [1:0][DATA_W-1:0] mem;
    logic                   wr_idx;
    logic                   rd_idx;
    logic [1:0]             count;
  } buf_state_t;

  buf_state_t q;
  buf_state_t d;
  logic       push;
  logic       pop;

  // ==========================================================================
  // handshake
  assign in_ready_o  = (q.count != 2'h2);
  assign out_valid_o = (q.count != 2'h0);
  assign out_data_o  = q.mem[q.rd_idx];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_idx] = in_data_i;
      d.wr_idx        = ~q.wr_idx;
    end
    if (pop) begin
      d.rd_idx = ~q.rd_idx;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : read_buffer

// *** blit_logic_unit.sv ***
// logical combine of source and destination under a mask
module blit_logic_unit
  import blit_pkg::*;
(
  input  wire logic_op_t op_i,
  input  wire logic      inv_i,
  input  wire word_t     src_i,
  input  wire word_t     dst_i,
  input  wire word_t     mask_i,
  output word_t          res_o
);

  word_t s;
  word_t r;

  // ==========================================================================
  // combine
  always_comb begin
    s = inv_i ? ~src_i : src_i;
    case (op_i)
      LOP_AND: r = s & dst_i;
      LOP_OR:  r = s | dst_i;
      LOP_XOR: r = s ^ dst_i;
      default: r = s;
    endcase
    res_o = (r & mask_i) | (dst_i & ~mask_i);
  end

endmodule : blit_logic_unit

// *** blit_engine.sv ***
// graphics block transfer unit: block ops, word or, external assist, pattern store, bit run test
//
// Summary of operation
// - combine source and destination by variant operation
// - fast or refuses inverted and decreasing options
// - width counts source words per line
// - odd byte source warp accepted
// - horizontal by option, vertical by warp sign
// - direction and polarity bits decode options
// - and-select bit set only for and
// - operation and size field codes decoded
// - word or stores double word, pointers plus two
// - word or shifts source up by shift
// - external transfer issues source, dest read, write
// - extra preload read unless last flag set
// - external transfer final register values
// - pattern stored count times, address plus increment
// - pattern store ends count zero, last address
// - bit run test operands, option one counts ones
// - option zero counts clear bits to limit
// - block setup from registers and stack width
// - zero mask bits leave destination unchanged
module blit_engine
  import blit_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              start_i,
  input  wire cmd_kind_t         cmd_kind_i,
  input  wire logic [23:0]       cmd_word_i,
  input  wire logic              run_option_i,
  input  wire gpr_file_t         regs_i,
  input  wire logic [31:0]       width_i,
  input  wire logic              psw_last_i,
  input  wire blit_cfg_t         bpu_cfg_i,
  output logic                   mem_req_o,
  output logic                   mem_we_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic [DATA_W-1:0]      mem_wdata_o,
  input  wire logic              mem_ack_i,
  input  wire logic [DATA_W-1:0] mem_rdata_i,
  output gpr_file_t              regs_o,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   illegal_o,
  output logic                   flag_f_o,
  output logic                   flag_l_o
);

  typedef enum logic [3:0] {
    S_IDLE, S_BB_SRC, S_BB_DST, S_BB_WR, S_AW_SRC, S_AW_DST, S_AW_WR,
    S_EX_PRE, S_EX_SRC, S_EX_DST, S_EX_WR, S_MP_WR, S_BR_RD, S_FIN
  } state_t;

  typedef struct packed {
    state_t      st;
    mem_req_t    mem;
    logic        wait_rd;
    gpr_file_t   gpr;
    logic [31:0] wcnt;
    logic [31:0] width;
    logic        first;
    word_t       carry;
    word_t       srcw;
    word_t       dstw;
    logic [31:0] dstd;
    bb_dec_t     bb;
    logic        lflag;
    logic        opt;
    logic        busy;
    logic        done;
    logic        illegal;
    logic        flag_f;
    logic        flag_l;
  } eng_state_t;

  eng_state_t        q;
  eng_state_t        d;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;
  logic              acc_done;
  logic [DATA_W-1:0] rdat;
  logic              bus_free;
  logic              ext_mode;
  logic_op_t         lu_op;
  logic              lu_inv;
  word_t             lu_src;
  word_t             lu_mask;
  word_t             lu_res;
  logic              rd_bit;
  logic signed [31:0] br_off;

  // ==========================================================================
  // helpers
  function automatic mem_req_t mem_op(input logic we, input logic [31:0] addr, input logic [DATA_W-1:0] data);
    mem_req_t m;
    m.req   = 1'b1;
    m.we    = we;
    m.addr  = addr[ADDR_W-1:0];
    m.wdata = data;
    return m;
  endfunction : mem_op

  // aligns source to destination using the previous word as fill
  function automatic word_t align(input word_t cur, input word_t prev, input logic dec, input logic [3:0] sh);
    logic [31:0] up;
    logic [31:0] dn;
    up = {cur, prev} << sh;
    dn = {prev, cur} >> sh;
    return dec ? dn[15:0] : up[31:16];
  endfunction : align

  function automatic bb_dec_t decode_bb(input logic [23:0] w);
    bb_dec_t     r;
    logic [3:0]  opf;
    logic [1:0]  sz;
    logic        andx;
    logic        frame;
    opf   = w[BB_OP_LSB +: 4];
    sz    = w[BB_SIZE_LSB +: 2];
    andx  = w[BB_AND_BIT];
    frame = (w[7:0] == BB_LOW_VAL) && (w[23:BB_HI_LSB] == BB_HI_VAL) && !w[BB_ZERO_BIT];
    r.dec = w[BB_DEC_BIT];
    r.inv = w[BB_INV_BIT];
    r.op  = LOP_COPY;
    r.ok  = 1'b0;
    if (frame) begin
      case (opf)
        OPF_AND: begin
          r.op = LOP_AND;
          r.ok = (sz == SIZE_AND) && andx;
        end
        OPF_OR: begin
          r.op = LOP_OR;
          r.ok = (sz == SIZE_REST) && !andx;
        end
        OPF_XOR: begin
          r.op = LOP_XOR;
          r.ok = (sz == SIZE_REST) && !andx;
        end
        OPF_FOR: begin
          r.op = LOP_OR;
          r.ok = (sz == SIZE_REST) && !andx && !r.inv && !r.dec;
        end
        OPF_COPY: begin
          r.op = LOP_COPY;
          r.ok = (sz == SIZE_REST) && !andx;
        end
        default: r.ok = 1'b0;
      endcase
    end
    return r;
  endfunction : decode_bb

  // ==========================================================================
  // read data buffer and combine unit
  read_buffer u_read_buffer (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (q.mem.req & ~q.mem.we & mem_ack_i),
    .in_data_i   (mem_rdata_i),
    .in_ready_o  (buf_in_ready),
    .out_valid_o (buf_out_valid),
    .out_data_o  (buf_out_data),
    .out_ready_i (q.wait_rd)
  );

  assign ext_mode = (q.st == S_EX_WR);
  assign lu_op    = ext_mode ? bpu_cfg_i.op : q.bb.op;
  assign lu_inv   = ext_mode ? bpu_cfg_i.inv : q.bb.inv;
  assign lu_src   = ext_mode ? align(q.srcw, q.carry, q.gpr.gpr4[31], bpu_cfg_i.shift)
                             : align(q.srcw, q.carry, q.bb.dec, q.gpr.gpr2[3:0]);
  assign rd_bit   = rdat[q.gpr.gpr1[2:0]];
  assign br_off   = $signed(q.gpr.gpr1) >>> BYTE_SHIFT;

  // edge masks apply to the first and last source word of a block transfer line; external transfers use no mask
  always_comb begin
    lu_mask = MASK_ALL;
    if (!ext_mode) begin
      if (q.first) begin
        lu_mask = lu_mask & q.gpr.gpr4[WORD_W-1:0];
      end
      if (q.wcnt == ONE) begin
        lu_mask = lu_mask & q.gpr.gpr5[WORD_W-1:0];
      end
    end
  end

  blit_logic_unit u_blit_logic_unit (
    .op_i   (lu_op),
    .inv_i  (lu_inv),
    .src_i  (lu_src),
    .dst_i  (q.dstw),
    .mask_i (lu_mask),
    .res_o  (lu_res)
  );

  // ==========================================================================
  // sequencer
  always_comb begin
    d        = q;
    d.done   = 1'b0;
    acc_done = 1'b0;
    rdat     = '0;
    bus_free = !q.mem.req && !q.wait_rd && buf_in_ready;
    if (q.mem.req && mem_ack_i) begin
      d.mem.req = 1'b0;
      if (q.mem.we) begin
        acc_done = 1'b1;
      end else begin
        d.wait_rd = 1'b1;
      end
    end
    if (q.wait_rd && buf_out_valid) begin
      acc_done  = 1'b1;
      rdat      = buf_out_data;
      d.wait_rd = 1'b0;
    end
    case (q.st)
      S_IDLE: begin
        if (start_i) begin
          d.gpr     = regs_i;
          d.width   = width_i;
          d.wcnt    = width_i;
          d.first   = 1'b1;
          d.carry   = '0;
          d.busy    = 1'b1;
          d.illegal = 1'b0;
          d.st      = S_FIN;
          case (cmd_kind_i)
            CMD_BLOCK: begin
              d.bb = decode_bb(cmd_word_i);
              if (!d.bb.ok) begin
                d.illegal = 1'b1;
              end else if (regs_i.gpr3 != '0 && width_i != '0) begin
                d.st = S_BB_SRC;
              end
            end
            CMD_WORD_OR: d.st = S_AW_SRC;
            CMD_EXTERNAL: begin
              d.gpr.gpr5 = regs_i.gpr2;
              d.lflag    = psw_last_i;
              if (regs_i.gpr3 != '0 && regs_i.gpr2 != '0) begin
                d.st = psw_last_i ? S_EX_SRC : S_EX_PRE;
              end
            end
            CMD_PATTERN: begin
              if (regs_i.gpr2 != '0) begin
                d.st = S_MP_WR;
              end
            end
            CMD_BIT_RUN: begin
              d.opt      = run_option_i;
              d.gpr.gpr2 = '0;
              if ($signed(regs_i.gpr1) >= $signed(regs_i.gpr4)) begin
                d.flag_f = run_option_i;
                d.flag_l = 1'b0;
              end else begin
                d.st = S_BR_RD;
              end
            end
            default: d.illegal = 1'b1;
          endcase
        end
      end
      S_BB_SRC: begin
        if (bus_free) begin
          d.mem = mem_op(1'b0, q.gpr.gpr0, '0);
        end
        if (acc_done) begin
          d.srcw = rdat[WORD_W-1:0];
          d.st   = S_BB_DST;
        end
      end
      S_BB_DST: begin
        if (bus_free) begin
          d.mem = mem_op(1'b0, q.gpr.gpr1, '0);
        end
        if (acc_done) begin
          d.dstw = rdat[WORD_W-1:0];
          d.st   = S_BB_WR;
        end
      end
      S_BB_WR: begin
        if (bus_free) begin
          d.mem = mem_op(1'b1, q.gpr.gpr1, {{(DATA_W-WORD_W){1'b0}}, lu_res});
        end
        if (acc_done) begin
          d.carry    = q.srcw;
          d.first    = 1'b0;
          d.wcnt     = q.wcnt - ONE;
          d.gpr.gpr0 = q.bb.dec ? q.gpr.gpr0 - WORD_STEP : q.gpr.gpr0 + WORD_STEP;
          d.gpr.gpr1 = q.bb.dec ? q.gpr.gpr1 - WORD_STEP : q.gpr.gpr1 + WORD_STEP;
          d.st       = S_BB_SRC;
          if (q.wcnt == ONE) begin
            d.gpr.gpr0 = d.gpr.gpr0 + q.gpr.gpr6;
            d.gpr.gpr1 = d.gpr.gpr1 + q.gpr.gpr7;
            d.gpr.gpr3 = q.gpr.gpr3 - ONE;
            d.wcnt     = q.width;
            d.first    = 1'b1;
            d.carry    = '0;
            if (q.gpr.gpr3 == ONE) begin
              d.st = S_FIN;
            end
          end
        end
      end
      S_AW_SRC: begin
        if (bus_free) begin
          d.mem = mem_op(1'b0, q.gpr.gpr0, '0);
        end
        if (acc_done) begin
          d.srcw = rdat[WORD_W-1:0];
          d.st   = S_AW_DST;
        end
      end
      S_AW_DST: begin
        if (bus_free) begin
          d.mem = mem_op(1'b0, q.gpr.gpr1, '0);
        end
        if (acc_done) begin
          d.dstd = rdat;
          d.st   = S_AW_WR;
        end
      end
      S_AW_WR: begin
        if (bus_free) begin
          d.mem = mem_op(1'b1, q.gpr.gpr1, q.dstd | ({16'h0000, q.srcw} << q.gpr.gpr2[4:0]));
        end
        if (acc_done) begin
          d.gpr.gpr0 = q.gpr.gpr0 + WORD_STEP;
          d.gpr.gpr1 = q.gpr.gpr1 + WORD_STEP;
          d.st       = S_FIN;
        end
      end
      S_EX_PRE: begin
        if (bus_free) begin
          d.mem = mem_op(1'b0, q.gpr.gpr0, '0);
        end
        if (acc_done) begin
          d.carry    = rdat[WORD_W-1:0];
          d.gpr.gpr0 = q.gpr.gpr0 + q.gpr.gpr4;
          d.st       = S_EX_SRC;
        end
      end
      S_EX_SRC: begin
        if (bus_free) begin
          d.mem = mem_op(1'b0, q.gpr.gpr0, '0);
        end
        if (acc_done) begin
          d.srcw = rdat[WORD_W-1:0];
          d.st   = S_EX_DST;
        end
      end
      S_EX_DST: begin
        if (bus_free) begin
          d.mem = mem_op(1'b0, q.gpr.gpr1, '0);
        end
        if (acc_done) begin
          d.dstw = rdat[WORD_W-1:0];
          d.st   = S_EX_WR;
        end
      end
      S_EX_WR: begin
        if (bus_free) begin
          d.mem = mem_op(1'b1, q.gpr.gpr1, {{(DATA_W-WORD_W){1'b0}}, lu_res});
        end
        if (acc_done) begin
          d.carry    = q.srcw;
          d.gpr.gpr0 = q.gpr.gpr0 + q.gpr.gpr4;
          d.gpr.gpr1 = q.gpr.gpr1 + q.gpr.gpr4;
          d.gpr.gpr5 = q.gpr.gpr5 - WORD_STEP;
          d.st       = S_EX_SRC;
          if (q.gpr.gpr5 <= WORD_STEP) begin
            d.gpr.gpr0 = q.gpr.gpr0 + q.gpr.gpr6;
            d.gpr.gpr1 = q.gpr.gpr1 + q.gpr.gpr7;
            d.gpr.gpr3 = q.gpr.gpr3 - ONE;
            d.gpr.gpr5 = q.gpr.gpr2;
            d.st       = q.lflag ? S_EX_SRC : S_EX_PRE;
            if (q.gpr.gpr3 == ONE) begin
              d.st = S_FIN;
            end
          end
        end
      end
      S_MP_WR: begin
        if (bus_free) begin
          d.mem = mem_op(1'b1, q.gpr.gpr0, q.gpr.gpr3);
        end
        if (acc_done) begin
          d.gpr.gpr2 = q.gpr.gpr2 - ONE;
          if (q.gpr.gpr2 == ONE) begin
            d.st = S_FIN;
          end else begin
            d.gpr.gpr0 = q.gpr.gpr0 + q.gpr.gpr1;
          end
        end
      end
      S_BR_RD: begin
        if (!q.mem.req && !q.wait_rd && q.gpr.gpr2 >= q.gpr.gpr3) begin
          d.flag_l = 1'b1;
          d.st     = S_FIN;
        end else if (bus_free) begin
          d.mem = mem_op(1'b0, q.gpr.gpr0 + br_off, '0);
        end
        if (acc_done) begin
          d.flag_f = rd_bit;
          if (rd_bit == q.opt) begin
            d.gpr.gpr2 = q.gpr.gpr2 + ONE;
            d.gpr.gpr1 = q.gpr.gpr1 + ONE;
            if ($signed(q.gpr.gpr1 + ONE) >= $signed(q.gpr.gpr4)) begin
              d.flag_l = 1'b0;
              d.st     = S_FIN;
            end
          end else begin
            d.flag_l = 1'b1;
            d.st     = S_FIN;
          end
        end
      end
      S_FIN: begin
        d.done = 1'b1;
        d.busy = 1'b0;
        d.st   = S_IDLE;
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign mem_req_o   = q.mem.req;
  assign mem_we_o    = q.mem.we;
  assign mem_addr_o  = q.mem.addr;
  assign mem_wdata_o = q.mem.wdata;
  assign regs_o      = q.gpr;
  assign busy_o      = q.busy;
  assign done_o      = q.done;
  assign illegal_o   = q.illegal;
  assign flag_f_o    = q.flag_f;
  assign flag_l_o    = q.flag_l;

endmodule : blit_engine

// *** blit_engine_sva.sv ***
// checker of the block transfer engine ports
module blit_engine_sva
  import blit_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        start_i,
  input wire cmd_kind_t   cmd_kind_i,
  input wire logic [23:0] cmd_word_i,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic        mem_ack_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        illegal_o
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic go;
  logic blk;
  assign go  = start_i && !busy_o;
  assign blk = go && cmd_kind_i == CMD_BLOCK;
  property p_busy_rise;
    go |=> busy_o;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");
  property p_done_pulse;
    done_o |-> !busy_o ##1 !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("bad done pulse");
  property p_req_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed early");
  property p_req_drop;
    mem_req_o && mem_ack_i |=> !mem_req_o;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  property p_read_gap;
    mem_req_o && mem_ack_i && !mem_we_o |=> !mem_req_o [*2];
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("read gap too short");
  property p_fast_refused;
    blk && cmd_word_i[13:10] == OPF_FOR && (cmd_word_i[BB_INV_BIT] || cmd_word_i[BB_DEC_BIT])
      |-> ##[1:3] (illegal_o && done_o);
  endproperty
  a_fast_refused: assert property (p_fast_refused) else $error("fast or option taken");
  property p_and_only;
    blk && cmd_word_i[BB_AND_BIT] && cmd_word_i[13:10] != OPF_AND |-> ##[1:3] (illegal_o && done_o);
  endproperty
  a_and_only: assert property (p_and_only) else $error("and bit taken");
  property p_legal_ok;
    blk && cmd_word_i == 24'h00110E |=> !illegal_o [*3];
  endproperty
  a_legal_ok: assert property (p_legal_ok) else $error("copy word refused");
endmodule : blit_engine_sva

// *** mem_model.sv ***
// memory partner answering the engine bus
module mem_model
  import blit_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              slow_i,
  input  wire logic              req_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic                   ack_o,
  output logic [DATA_W-1:0]      rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // storage and answer
  logic [DATA_W-1:0] mem [0:255];
  logic [2:0]        wait_q = 3'h0;
  int                n_rd   = 0;
  initial begin
    ack_o   = 1'b0;
    rdata_o = 32'h0000_0000;
  end
  // one-cycle ack, data only with it
  always @(posedge sys_clk_i) begin
    if (req_i && !ack_o && (wait_q == 3'h3 || !slow_i)) begin
      ack_o  <= 1'b1;
      wait_q <= 3'h0;
      if (we_i) mem[addr_i[7:0]] <= wdata_i;
      else begin
        rdata_o <= mem[addr_i[7:0]];
        n_rd    <= n_rd + 1;
      end
    end else begin
      ack_o   <= 1'b0;
      wait_q  <= req_i ? wait_q + 3'h1 : 3'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : mem_model

// *** tb.sv ***
// testbench of the block transfer engine
module tb;
  import blit_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  cmd_kind_t   kind = CMD_BLOCK;
  logic [23:0] word = 24'h00_0000;
  logic        opt = 1'b0;
  logic        last = 1'b0;
  logic        slow = 1'b0;
  gpr_file_t   regs = '0;
  logic [31:0] width = 32'h0000_0001;
  blit_cfg_t   cfg = '0;
  logic        req, we, ack, busy, done, ill, ff, fl;
  logic [23:0] addr;
  logic [31:0] wdata, rdata;
  gpr_file_t   rout;
  int          err_total = 0;
  int          n_checks = 0;
  always #50 clk = ~clk;
  blit_engine uut (.sys_clk_i(clk), .reset_n_i(rst_n), .start_i(start), .cmd_kind_i(kind),
    .cmd_word_i(word), .run_option_i(opt), .regs_i(regs), .width_i(width), .psw_last_i(last),
    .bpu_cfg_i(cfg), .mem_req_o(req), .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wdata),
    .mem_ack_i(ack), .mem_rdata_i(rdata), .regs_o(rout), .busy_o(busy), .done_o(done),
    .illegal_o(ill), .flag_f_o(ff), .flag_l_o(fl));
  mem_model m (.sys_clk_i(clk), .slow_i(slow), .req_i(req), .we_i(we), .addr_i(addr),
    .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata));
  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic run(input cmd_kind_t k, input logic [23:0] w);
    int cy;
    kind  = k;
    word  = w;
    start = 1'b1;
    @(posedge clk) #1;
    start = 1'b0;
    for (cy = 0; cy < 400 && done !== 1'b1; cy++) @(posedge clk) #1;
    chk(done, 1'b1);
  endtask : run
  task automatic t_block();
    logic [23:0] w [8] = '{24'h012B0E, 24'h00190E, 24'h00390E, 24'h00310E, 24'h00110E, 24'h00B90E, 24'h00910E,
                           24'h02110E};
    logic [15:0] e [8] = '{16'h5500, 16'h55FF, 16'h55FF, 16'h55FF, 16'h55AA, 16'h5500, 16'h5555, 16'h55AA};
    for (int i = 0; i < 8; i++) begin
      m.mem[8'h40] = 32'h0000_AAAA;
      m.mem[8'h50] = 32'h0000_5555;
      regs         = '0;
      regs.gpr0    = 32'h40;
      regs.gpr1    = 32'h50;
      regs.gpr3    = 32'h1;
      regs.gpr4    = 32'h00FF;
      regs.gpr5    = 32'h00FF;
      slow         = i[0];
      run(CMD_BLOCK, w[i]);
      chk(m.mem[8'h50][15:0], e[i]);
      chk(ill, 1'b0);
      chk(rout.gpr0, w[i][17] ? 32'h3E : 32'h42);
    end
  endtask : t_block
  task automatic t_refuse();
    logic [23:0] w [4] = '{24'h00B10E, 24'h02310E, 24'h01290E, 24'h01190E};
    for (int i = 0; i < 4; i++) begin
      run(CMD_BLOCK, w[i]);
      chk({done, ill}, 2'b11);
    end
  endtask : t_refuse
  task automatic t_pattern();
    m.mem[8'hF4] = 32'h0000_0000;
    regs         = '0;
    regs.gpr0    = 32'h100;
    regs.gpr1    = 32'hFFFF_FFFC;
    regs.gpr2    = 32'h3;
    regs.gpr3    = 32'hC3C3_5A5A;
    slow         = 1'b1;
    run(CMD_PATTERN, 24'h00_0000);
    chk(m.mem[8'h00] & m.mem[8'hFC] & m.mem[8'hF8], 32'hC3C3_5A5A);
    chk(m.mem[8'hF4], 32'h0);
    chk(rout.gpr0, 32'hF8);
    chk(rout.gpr2 | (rout.gpr1 ^ 32'hFFFF_FFFC) | (rout.gpr3 ^ 32'hC3C3_5A5A), 32'h0);
  endtask : t_pattern
  task automatic t_word_or();
    m.mem[8'h10] = 32'h0000_1234;
    m.mem[8'h20] = 32'h0F00_0001;
    regs         = '0;
    regs.gpr0    = 32'h10;
    regs.gpr1    = 32'h20;
    regs.gpr2    = 32'h4;
    run(CMD_WORD_OR, 24'h00_0000);
    chk(m.mem[8'h20], 32'h0F01_2341);
    chk({rout.gpr1[7:0], rout.gpr0[7:0]}, 32'h2212);
  endtask : t_word_or
  task automatic t_external();
    int base;
    for (int l = 0; l < 2; l++) begin
      m.mem[8'h70] = 32'h0000_1111;
      m.mem[8'h72] = 32'h0000_2222;
      m.mem[8'h74] = 32'h0000_3333;
      regs         = '0;
      regs.gpr0    = 32'h70;
      regs.gpr1    = 32'h80;
      regs.gpr2    = 32'h4;
      regs.gpr3    = 32'h1;
      regs.gpr4    = 32'h2;
      regs.gpr6    = 32'h10;
      regs.gpr7    = 32'h20;
      cfg.op       = LOP_COPY;
      last         = l[0];
      base         = m.n_rd;
      run(CMD_EXTERNAL, 24'h00_0000);
      chk(m.n_rd - base, l[0] ? 32'h4 : 32'h5);
    end
    chk({m.mem[8'h82][15:0], m.mem[8'h80][15:0]}, 32'h2222_1111);
    chk({rout.gpr1[7:0], rout.gpr0[7:0]}, 32'hA282);
    chk(rout.gpr4 ^ 32'h2 | rout.gpr6 ^ 32'h10 | rout.gpr7 ^ 32'h20, 32'h0);
  endtask : t_external
  task automatic t_bit_run();
    m.mem[8'h60] = 32'h0000_0007;
    m.mem[8'h61] = 32'h0000_0000;
    regs         = '0;
    regs.gpr0    = 32'h60;
    regs.gpr3    = 32'h8;
    regs.gpr4    = 32'h10;
    opt          = 1'b1;
    run(CMD_BIT_RUN, 24'h00_0000);
    chk({rout.gpr2[7:0], rout.gpr1[7:0], 14'h0000, ff, fl}, 32'h0303_0001);
    regs.gpr1    = 32'h8;
    regs.gpr3    = 32'h4;
    opt          = 1'b0;
    run(CMD_BIT_RUN, 24'h00_0000);
    chk({rout.gpr2[7:0], rout.gpr1[7:0], 14'h0000, ff, fl}, 32'h040C_0001);
  endtask : t_bit_run
  // ==========================================================================
  // sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    t_block();
    t_refuse();
    t_pattern();
    t_word_or();
    t_external();
    t_bit_run();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule : tb
bind blit_engine blit_engine_sva sva (.sys_clk_i, .reset_n_i, .start_i, .cmd_kind_i, .cmd_word_i,
  .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .busy_o, .done_o, .illegal_o);
